// ---- logic/octal_serial_pkg.sv ----
/*
 * constants for the eight-port serial handshake block.
 * assumes a 25 MHz system clock and a host bus with select/strobe/ack pins.
 */
package octal_serial_pkg;
  localparam int          NUM_PORTS     = 8;
  localparam int          CLK_HZ        = 25000000;
  localparam int          BAUD_HZ       = 115200;
  localparam int          BIT_CYCLES    = CLK_HZ / BAUD_HZ;
  localparam logic [15:0] BIT_CNT_MAX   = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_CNT      = 16'(BIT_CYCLES / 2);
  localparam logic [3:0]  MIN_DATA_BITS = 4'h5;
  localparam logic [3:0]  MAX_DATA_BITS = 4'h8;
  // host address layout: bits [5:3] port, bits [2:0] register
  localparam int          PORT_SEL_LSB  = 3;
  localparam logic [2:0]  REG_DATA      = 3'h0;
  localparam logic [2:0]  REG_FORMAT    = 3'h1;
  localparam logic [2:0]  REG_STATUS    = 3'h2;
  localparam logic [2:0]  REG_INT_PORT  = 3'h3;
  localparam logic [7:0]  ID_VALUE      = 8'h5a; // arbitrary identification value
  localparam logic [7:0]  FORMAT_RESET  = 8'h03;
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} line_state_e;
endpackage : octal_serial_pkg

// ---- logic/octal_serial_port_handshake.sv ----
/*
 * eight-port async serial block: per-port tx/rx with active-low rts/cts,
 * host access decode with acknowledge, fixed-priority interrupt presenter.
 * assumes synchronous host strobes and line inputs already in this clock domain.
 */
// Function
// - idle transmit line stays at mark (one).
// - shifting starts only while own rts and incoming cts are both asserted.
// - rts asserts when a character is ready to send.
// - rts holds through transmit and drops after finish; the code keeps rts asserted if another character was written during the frame.
// - rts and cts are active low.
// - serial to parallel and back, with one-character buffer each way.
// - decode io space accesses into per-port selects and strobes; id space reads return the id value.
// - every decoded access returns one acknowledge.
// - simultaneous port interrupts served in priority order, one at a time.
// - frame is start bit, five to eight data bits, optional parity, stop bits.
`timescale 1ns/1ps
module octal_serial_port_handshake
  import octal_serial_pkg::*;
(
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_srst,
  input  wire logic                 i_clk_en,
  input  wire logic                 i_io_sel,
  input  wire logic                 i_id_sel,
  input  wire logic                 i_wr,
  input  wire logic [5:0]           i_addr,
  input  wire logic [7:0]           i_wdata,
  output logic      [7:0]           o_rdata,
  output logic                      o_ack,
  output logic      [NUM_PORTS-1:0] o_port_cs,
  output logic                      o_int_req,
  input  wire logic [NUM_PORTS-1:0] i_rxd,
  input  wire logic [NUM_PORTS-1:0] i_cts_n,
  output logic      [NUM_PORTS-1:0] o_txd,
  output logic      [NUM_PORTS-1:0] o_rts_n,
  output logic      [NUM_PORTS-1:0] o_port_irq
);

  // ****************************************************************
  // host decode
  // ****************************************************************
  logic [2:0] port_idx;
  logic [2:0] reg_idx;
  logic       access;
  logic       ack_busy;
  logic [7:0] rd_mux;
  logic [7:0] port_rd [NUM_PORTS];
  logic [2:0] int_port;

  assign port_idx = i_addr[PORT_SEL_LSB +: 3];
  assign reg_idx  = i_addr[2:0];
  // one access per select assertion; host must drop select before the next
  assign access   = (i_io_sel | i_id_sel) & ~ack_busy;

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      o_port_cs[p] = i_io_sel & (port_idx == 3'(p));
    end
  end

  always_comb begin
    if (i_id_sel) begin
      rd_mux = ID_VALUE;
    end else if (reg_idx == REG_INT_PORT) begin
      rd_mux = {4'h0, o_int_req, int_port};
    end else begin
      rd_mux = port_rd[port_idx];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_ack    <= 1'b0;
      ack_busy <= 1'b0;
      o_rdata  <= 8'h00;
    end else if (i_clk_en) begin
      o_ack <= access;
      if (access) begin
        ack_busy <= 1'b1;
        o_rdata  <= rd_mux;
      end else if (!i_io_sel && !i_id_sel) begin
        ack_busy <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // interrupt priority: lowest port number wins
  // ****************************************************************
  always_comb begin
    int_port = 3'h0;
    for (int p = NUM_PORTS - 1; p >= 0; p--) begin
      if (o_port_irq[p]) begin
        int_port = 3'(p);
      end
    end
  end
  assign o_int_req = |o_port_irq;

  // ****************************************************************
  // per-port serial engines
  // ****************************************************************
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic        wr_hit;
    logic        rd_hit;
    logic [7:0]  fmt;       // [1:0] len-5, [2] two stop, [3] parity en, [4] even
    logic [7:0]  tx_hold;
    logic        tx_full;
    line_state_e tx_st;
    logic [15:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [7:0]  tx_sh;
    logic        tx_par;
    logic [7:0]  rx_buf;
    logic        rx_full;
    logic        rx_err;
    line_state_e rx_st;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic        rx_par;
    logic [3:0]  nbits;
    logic        tick_tx;
    logic        tick_rx;

    assign nbits   = MIN_DATA_BITS + {2'b00, fmt[1:0]};
    assign wr_hit  = access & o_port_cs[p] & i_wr;
    assign rd_hit  = access & o_port_cs[p] & ~i_wr;
    assign tick_tx = (tx_cnt == BIT_CNT_MAX);
    assign tick_rx = (rx_cnt == BIT_CNT_MAX);
    assign port_rd[p] = (reg_idx == REG_DATA)   ? rx_buf :
                        (reg_idx == REG_FORMAT) ? fmt :
                        (reg_idx == REG_STATUS) ? {4'h0, rx_err, ~i_cts_n[p], tx_full, rx_full} :
                        8'h00;
    // irq: character waiting, or room to send
    assign o_port_irq[p] = rx_full | ~tx_full;

    always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
        fmt <= FORMAT_RESET;
      end else if (i_clk_en && wr_hit && reg_idx == REG_FORMAT) begin
        fmt <= i_wdata;
      end
    end

    // transmit side
    always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
        tx_hold    <= 8'h00;
        tx_full    <= 1'b0;
        tx_st      <= S_IDLE;
        tx_cnt     <= 16'h0000;
        tx_bit     <= 4'h0;
        tx_sh      <= 8'h00;
        tx_par     <= 1'b0;
        o_txd[p]   <= 1'b1;
        o_rts_n[p] <= 1'b1;
      end else if (i_clk_en) begin
        tx_cnt <= (tx_st == S_IDLE || tick_tx) ? 16'h0000 : tx_cnt + 16'h0001;
        unique case (tx_st)
          S_IDLE: begin
            o_txd[p]   <= 1'b1;
            o_rts_n[p] <= ~tx_full;
            if (tx_full && !o_rts_n[p] && !i_cts_n[p]) begin
              tx_sh    <= tx_hold;
              tx_par   <= ~fmt[4];
              tx_full  <= 1'b0;
              tx_st    <= S_START;
              o_txd[p] <= 1'b0;
            end
          end
          S_START: if (tick_tx) begin
            tx_bit   <= 4'h0;
            o_txd[p] <= tx_sh[0];
            tx_par   <= tx_par ^ tx_sh[0];
            tx_sh    <= tx_sh >> 1;
            tx_st    <= S_DATA;
          end
          S_DATA: if (tick_tx) begin
            if (tx_bit == nbits - 4'h1) begin
              tx_bit   <= 4'h0;
              o_txd[p] <= fmt[3] ? tx_par : 1'b1;
              tx_st    <= fmt[3] ? S_PAR : S_STOP;
            end else begin
              tx_bit   <= tx_bit + 4'h1;
              o_txd[p] <= tx_sh[0];
              tx_par   <= tx_par ^ tx_sh[0];
              tx_sh    <= tx_sh >> 1;
            end
          end
          S_PAR: if (tick_tx) begin
            o_txd[p] <= 1'b1;
            tx_st    <= S_STOP;
          end
          S_STOP: if (tick_tx) begin
            if (fmt[2] && tx_bit == 4'h0) begin
              tx_bit <= 4'h1;
            end else begin
              tx_st      <= S_IDLE;
              o_rts_n[p] <= ~tx_full;
            end
          end
          default: tx_st <= S_IDLE;
        endcase
        // after the case: a write landing as the hold empties keeps the flag set
        if (wr_hit && reg_idx == REG_DATA) begin
          tx_hold <= i_wdata;
          tx_full <= 1'b1;
        end
      end
    end

    // receive side, sampled mid-bit
    always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
        rx_buf  <= 8'h00;
        rx_full <= 1'b0;
        rx_err  <= 1'b0;
        rx_st   <= S_IDLE;
        rx_cnt  <= 16'h0000;
        rx_bit  <= 4'h0;
        rx_sh   <= 8'h00;
        rx_par  <= 1'b0;
      end else if (i_clk_en) begin
        if (rd_hit && reg_idx == REG_DATA) begin
          rx_full <= 1'b0;
        end
        rx_cnt <= (rx_st == S_IDLE || tick_rx) ? 16'h0000 : rx_cnt + 16'h0001;
        unique case (rx_st)
          S_IDLE: if (!i_rxd[p]) begin
            rx_st  <= S_START;
            rx_cnt <= HALF_CNT;
          end
          S_START: if (tick_rx) begin
            // glitch shorter than half a bit is not a start
            rx_st  <= i_rxd[p] ? S_IDLE : S_DATA;
            rx_bit <= 4'h0;
            rx_sh  <= 8'h00;
            rx_par <= ~fmt[4];
          end
          S_DATA: if (tick_rx) begin
            rx_sh[rx_bit[2:0]] <= i_rxd[p];
            rx_par             <= rx_par ^ i_rxd[p];
            rx_bit             <= rx_bit + 4'h1;
            if (rx_bit == nbits - 4'h1) begin
              rx_st <= fmt[3] ? S_PAR : S_STOP;
            end
          end
          S_PAR: if (tick_rx) begin
            rx_par <= rx_par ^ i_rxd[p];
            rx_st  <= S_STOP;
          end
          S_STOP: if (tick_rx) begin
            // new character overwrites; set wins over host read clear
            rx_buf  <= rx_sh;
            rx_full <= 1'b1;
            rx_err  <= ~i_rxd[p] | (fmt[3] & rx_par);
            rx_st   <= S_IDLE;
          end
          default: rx_st <= S_IDLE;
        endcase
      end
    end
  end

endmodule : octal_serial_port_handshake

// ---- testbench/octal_serial_port_handshake_checker.sv ----
/* port-level assertions for the eight-port serial block.
   assumes it is bound to the block and the package is compiled first. */
`timescale 1ns/1ps
module octal_serial_port_handshake_checker
  import octal_serial_pkg::*;
(
  input wire logic                 i_clk_sys,
  input wire logic                 i_srst,
  input wire logic                 i_clk_en,
  input wire logic                 i_io_sel,
  input wire logic                 i_id_sel,
  input wire logic                 i_wr,
  input wire logic [5:0]           i_addr,
  input wire logic [NUM_PORTS-1:0] i_cts_n,
  input wire logic [7:0]           o_rdata,
  input wire logic                 o_ack,
  input wire logic [NUM_PORTS-1:0] o_port_cs,
  input wire logic                 o_int_req,
  input wire logic [NUM_PORTS-1:0] o_txd,
  input wire logic [NUM_PORTS-1:0] o_rts_n,
  input wire logic [NUM_PORTS-1:0] o_port_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  idle_mark_a: assert property ((o_txd | ~o_rts_n) == '1)
    else $error("txd off mark while idle");
  start_gate_a: assert property (
    ((~o_txd & $past(o_txd)) & ($past(o_rts_n) | $past(i_cts_n))) == '0)
    else $error("txd fell without rts and cts");
  rts_request_a: assert property (
    $rose(i_io_sel) && i_clk_en && i_wr && i_addr == 6'h00 && o_rts_n[0]
    |-> ##[1:3] !o_rts_n[0])
    else $error("rts not raised for pending char");
  rts_hold_a: assert property ($rose(o_rts_n[0]) |-> $past(o_txd[0], 200))
    else $error("rts released before stop bit done");
  ack_answer_a: assert property ($rose(i_io_sel | i_id_sel) && i_clk_en |=> o_ack)
    else $error("no ack one cycle after access");
  ack_pulse_a: assert property (o_ack |=> !o_ack)
    else $error("ack longer than one cycle");
  port_select_a: assert property (o_port_cs == (i_io_sel ? 8'h01 << i_addr[5:3] : 8'h00))
    else $error("port select mismatch");
  id_value_a: assert property ($rose(i_id_sel) && !i_wr |=> o_rdata == ID_VALUE)
    else $error("id read value wrong");
  irq_merge_a: assert property (o_int_req == |o_port_irq)
    else $error("int request not merged");
endmodule : octal_serial_port_handshake_checker
bind octal_serial_port_handshake octal_serial_port_handshake_checker chk (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_clk_en(i_clk_en), .i_io_sel(i_io_sel),
  .i_id_sel(i_id_sel),
  .i_wr(i_wr), .i_addr(i_addr), .i_cts_n(i_cts_n), .o_rdata(o_rdata), .o_ack(o_ack),
  .o_port_cs(o_port_cs), .o_int_req(o_int_req), .o_txd(o_txd), .o_rts_n(o_rts_n),
  .o_port_irq(o_port_irq));

// ---- testbench/modem_partner.sv ----
/* modem model for all eight ports: cts follows rts after a lag, data looped back.
   assumes one clock shared with the block. */
`timescale 1ns/1ps
module modem_partner
  import octal_serial_pkg::*;
(
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_slow,
  input  wire logic [NUM_PORTS-1:0] i_rts_n,
  input  wire logic [NUM_PORTS-1:0] i_txd,
  output logic      [NUM_PORTS-1:0] o_cts_n,
  output logic      [NUM_PORTS-1:0] o_rxd
);
  logic [NUM_PORTS-1:0] lag [0:39] = '{default: '1};
  // line turned around at the far end; txd idles at mark so rxd does too
  assign o_rxd = i_txd;
  always @(posedge i_clk_sys) begin
    lag[0] <= i_rts_n;
    for (int k = 1; k < 40; k++) lag[k] <= lag[k-1];
  end
  // slow mode lets the block sit with rts on and cts off
  assign o_cts_n = i_slow ? lag[39] : lag[1];
endmodule : modem_partner

// ---- testbench/octal_serial_port_handshake_test.sv ----
/* self-checking bench: host bus tasks, frame sampling on the wire, loopback rx.
   assumes package, design, checker and modem model are compiled first. */
`timescale 1ns/1ps
module octal_serial_port_handshake_test;
  import octal_serial_pkg::*;
  logic                 i_clk_sys, i_srst, i_io_sel, i_id_sel, i_wr, slow, clk_en;
  logic [5:0]           i_addr;
  logic [7:0]           i_wdata, o_rdata;
  logic                 o_ack, o_int_req;
  logic [NUM_PORTS-1:0] o_port_cs, rxd, cts_n, o_txd, o_rts_n, o_port_irq;
  int                   failures, num_checks;
  octal_serial_port_handshake DUT (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_clk_en(clk_en),
    .i_io_sel(i_io_sel), .i_id_sel(i_id_sel), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .o_ack(o_ack), .o_port_cs(o_port_cs), .o_int_req(o_int_req),
    .i_rxd(rxd), .i_cts_n(cts_n), .o_txd(o_txd), .o_rts_n(o_rts_n), .o_port_irq(o_port_irq));
  modem_partner modem (.i_clk_sys(i_clk_sys), .i_slow(slow), .i_rts_n(o_rts_n),
    .i_txd(o_txd), .o_cts_n(cts_n), .o_rxd(rxd));
  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // select held one cycle past ack, then one idle cycle before the next access
  task automatic bus(input logic id, input logic wr, input logic [5:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge i_clk_sys);
    #1;
    {i_id_sel, i_io_sel, i_wr, i_addr, i_wdata} = {id, !id, wr, a, d};
    n = 0;
    do begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end while (o_ack !== 1'b1 && n < 20);
    check(8'(n), 8'h01, "ack latency");
    q = o_rdata;
    @(posedge i_clk_sys);
    #1;
    {i_id_sel, i_io_sel} = 2'b00;
  endtask : bus
  task automatic wait_idle(input int p);
    int n;
    n = 0;
    while (o_rts_n[p] !== 1'b1 && n < 4000) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    check(8'(o_rts_n[p]), 8'h01, "rts released");
    repeat (4) @(posedge i_clk_sys);
  endtask : wait_idle
  task automatic frame(input int p, input logic [7:0] fmt, input logic [7:0] d);
    logic [7:0]  q, mask;
    logic [11:0] bits;
    int          nb, nf, n;
    nb = int'(fmt[1:0]) + 5;
    mask = 8'(8'hff >> (8 - nb));
    bits = '1;
    bits[0] = 1'b0;
    for (int k = 0; k < nb; k++) bits[k+1] = d[k];
    if (fmt[3]) bits[nb+1] = ^(d & mask) ^ !fmt[4];
    nf = nb + 2 + int'(fmt[3]) + int'(fmt[2]);
    bus(0, 1, 6'(p * 8 + 1), fmt, q);
    bus(0, 1, 6'(p * 8), d, q);
    n = 0;
    while (o_txd[p] !== 1'b0 && n < 3000) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
    check(8'(cts_n[p]), 8'h00, "cts before start");
    repeat (BIT_CYCLES / 2) @(posedge i_clk_sys);
    for (int k = 0; k < nf; k++) begin
      check(8'(o_txd[p]), 8'(bits[k]), "frame bit");
      check(8'(o_rts_n[p]), 8'h00, "rts in frame");
      repeat (BIT_CYCLES) @(posedge i_clk_sys);
    end
    wait_idle(p);
    bus(0, 0, 6'(p * 8 + 2), 8'h00, q);
    check(q, 8'h01, "status after frame");
    bus(0, 0, 6'(p * 8), 8'h00, q);
    check(q, d & mask, "loopback char");
    $display("frame on port %0d done", p);
  endtask : frame
  task automatic irq_order();
    logic [7:0] q;
    bus(0, 0, 6'h03, 8'h00, q);
    check(q, 8'h08, "int after reset");
    bus(0, 1, 6'h00, 8'h81, q);
    bus(0, 0, 6'h03, 8'h00, q);
    check(q, 8'h09, "int next port");
    bus(0, 0, 6'h02, 8'h00, q);
    check(q, 8'h02, "status cts off");
    check(8'(o_txd[0]), 8'h01, "txd waits for cts");
    check(8'(o_rts_n[0]), 8'h00, "rts pending");
    wait_idle(0);
    bus(0, 0, 6'h00, 8'h00, q);
    check(q, 8'h81, "first char");
    $display("interrupt order done");
  endtask : irq_order
  task automatic reset_id();
    logic [7:0] q;
    check(o_txd, 8'hff, "txd at mark");
    check(o_rts_n, 8'hff, "rts off high");
    check(o_port_irq, 8'hff, "each port irq");
    bus(1, 0, 6'h2a, 8'h00, q);
    check(q, ID_VALUE, "id read");
    $display("reset and id done");
  endtask : reset_id
  // a write held while the enable is low must leave no trace
  task automatic freeze();
    @(posedge i_clk_sys);
    #1;
    clk_en = 1'b0;
    {i_id_sel, i_io_sel, i_wr, i_addr, i_wdata} = {1'b0, 1'b1, 1'b1, 6'h10, 8'h55};
    repeat (4) @(posedge i_clk_sys);
    #1;
    check(8'(o_ack), 8'h00, "ack while frozen");
    check(8'(o_rts_n[2]), 8'h01, "rts while frozen");
    {i_id_sel, i_io_sel} = 2'b00;
    @(posedge i_clk_sys);
    #1;
    clk_en = 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1;
    check(8'(o_rts_n[2]), 8'h01, "no char after freeze");
    $display("clock enable freeze done");
  endtask : freeze
  initial begin
    repeat (40000) @(posedge i_clk_sys);
    failures++;
    wrap_up();
  end
  initial begin
    {i_io_sel, i_id_sel, i_wr, i_addr, i_wdata, slow} = '0;
    clk_en = 1'b1;
    i_srst = 1'b1;
    repeat (3) @(posedge i_clk_sys);
    #1;
    i_srst = 1'b0;
    reset_id();
    slow = 1'b1;
    irq_order();
    freeze();
    slow = 1'b0;
    frame(0, 8'h03, 8'ha5);
    frame(7, 8'h18, 8'h13);
    frame(3, 8'h0e, 8'h5c);
    slow = 1'b1;
    frame(5, 8'h09, 8'h36);
    wrap_up();
  end
endmodule : octal_serial_port_handshake_test
